// file: logic/core_message_mailboxes.sv
// Mailbox unit of one engine's memory flow controller, with its queue
//
// Notes on behaviour
// - each entry holds one separate 32-bit word
// - inbound four deep, two outbound one deep
// - core uses channels, others use register port
// - non-blocking core access answers within six cycles
// - interrupting queue interrupts; three availability events
// - reading a message removes its entry
// - inbound counter counts valid entries
// - outbound counters count empty entries
// - every queue returns oldest message first
// - external write to full inbound overwrites newest
// - core write to full outbound stalls
// - core read of empty inbound stalls
// - external empty read: invalid word, no change
// - counters readable apart from message data
// - engine DMA accesses treated like processor's
// - external inbound write or outbound read signals core
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Generic queue with an optional overwrite-newest mode

module msg_fifo #(
	parameter int WIDTH = mbox_pkg::MSG_W,
	parameter int DEPTH = mbox_pkg::RSP_DEPTH,
	localparam int CW = $clog2(DEPTH + 1),
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             overwrite,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [CW-1:0]         count
);

	if (DEPTH < 1 || WIDTH < 1) begin : g_chk
		$error("msg_fifo needs DEPTH and WIDTH of at least one");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               rp;
		logic [PW-1:0]               wp;
		logic [CW-1:0]               cnt;
	} fifo_st_t;

	fifo_st_t r;
	fifo_st_t nxt;
	logic     full;
	logic     do_rd;
	logic     do_wr;
	logic     ovr;

	// Pointer steps with wrap at the depth
	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	function automatic logic [PW-1:0] back(input logic [PW-1:0] p);
		back = (p == '0) ? PW'(DEPTH - 1) : p - 1'b1;
	endfunction

	// Handshake faces straight from the state
	assign full      = (r.cnt == CW'(DEPTH));
	assign in_ready  = !full || overwrite;
	assign out_valid = (r.cnt != '0);
	assign out_data  = r.mem[r.rp];
	assign count     = r.cnt;

	// Oldest word leaves first, one word per entry
	always_comb begin
		nxt   = r;
		do_rd = out_valid && out_ready;
		do_wr = in_valid && in_ready;
		ovr   = do_wr && full && !do_rd;
		if (do_wr) begin
			if (ovr) begin
				nxt.mem[back(r.wp)] = in_data;
			end else begin
				nxt.mem[r.wp] = in_data;
				nxt.wp        = step(r.wp);
			end
		end
		if (do_rd) begin
			nxt.rp = step(r.rp);
		end
		case ({do_wr && !ovr, do_rd})
			2'b10:   nxt.cnt = r.cnt + 1'b1;
			2'b01:   nxt.cnt = r.cnt - 1'b1;
			default: nxt.cnt = r.cnt;
		endcase
	end

	// Reset empties the queue
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////
// Mailbox unit: channel side for the local core, register side for
// the control processor and other engines. Both sides are same-clock
// logic, so no input synchronisers are needed.

module core_message_mailboxes #(
	parameter int IN_DEPTH   = mbox_pkg::IN_DEPTH,
	parameter int OUT_DEPTH  = mbox_pkg::OUT_DEPTH,
	parameter int OUTI_DEPTH = mbox_pkg::OUTI_DEPTH,
	parameter int RSP_DEPTH  = mbox_pkg::RSP_DEPTH
) (
	input  wire logic                             clk_sys,
	input  wire logic                             srst,
	input  wire logic                             ch_valid,
	output logic                                  ch_ready,
	input  wire mbox_pkg::ch_sel_t                ch_sel,
	input  wire logic [mbox_pkg::MSG_W-1:0]       ch_wdata,
	output logic                                  ch_rsp_valid,
	input  wire logic                             ch_rsp_ready,
	output logic [mbox_pkg::MSG_W-1:0]            ch_rsp_data,
	input  wire logic                             ext_valid,
	input  wire logic                             ext_write,
	input  wire logic [mbox_pkg::EXT_AW-1:0]      ext_addr,
	input  wire logic [mbox_pkg::MSG_W-1:0]       ext_wdata,
	output logic                                  ext_rsp_valid,
	output logic [mbox_pkg::MSG_W-1:0]            ext_rsp_data,
	output logic                                  ext_rsp_ok,
	output logic                                  evt_in_written,
	output logic                                  evt_out_read,
	output logic                                  evt_out_intr_read,
	output logic                                  ctrl_irq
);

	localparam int W     = mbox_pkg::MSG_W;
	localparam int ICW   = $clog2(IN_DEPTH + 1);
	localparam int OCW   = $clog2(OUT_DEPTH + 1);
	localparam int QCW   = $clog2(OUTI_DEPTH + 1);
	localparam int LAT   = mbox_pkg::NB_LAT_MAX;

	if (IN_DEPTH < 1 || OUT_DEPTH < 1 || OUTI_DEPTH < 1 ||
			RSP_DEPTH < 2 || IN_DEPTH > 255 || OUT_DEPTH > 255 ||
			OUTI_DEPTH > 255) begin : g_chk
		$error("mailbox depths out of range");
	end

	// Registered answers and events toward both sides
	typedef struct packed {
		logic [W-1:0] rdata;
		logic         rvalid;
		logic         rok;
		logic         ev_in;
		logic         ev_out;
		logic         ev_outi;
	} mb_st_t;

	mb_st_t           r;
	mb_st_t           nxt;

	logic             in_vld;
	logic [W-1:0]     in_dout;
	logic [ICW-1:0]   in_cnt;
	logic             in_pop;
	logic             ext_in_wr;
	logic             out_rdy;
	logic             out_vld;
	logic [W-1:0]     out_dout;
	logic [OCW-1:0]   out_cnt;
	logic             out_push;
	logic             out_pop;
	logic             outi_rdy;
	logic             outi_vld;
	logic [W-1:0]     outi_dout;
	logic [QCW-1:0]   outi_cnt;
	logic             outi_push;
	logic             outi_pop;
	logic             rsp_rdy;
	logic             rsp_push;
	logic [W-1:0]     rsp_word;
	logic             ext_rd;

	// Counter value as a message-width word
	function automatic logic [W-1:0] as_word(input logic [7:0] v);
		as_word = W'(v);
	endfunction

	// Free entries of an outbound queue
	function automatic logic [W-1:0] free_word(input int depth,
			input logic [7:0] used);
		free_word = as_word(8'(depth) - used);
	endfunction

	////////////////////////////////////////////////////////////////
	// Queues

	// Inbound: external writes never wait, full overwrites newest
	msg_fifo #(.WIDTH(W), .DEPTH(IN_DEPTH)) u_in_q (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.in_valid  (ext_in_wr),
		.in_ready  (),
		.in_data   (ext_wdata),
		.overwrite (1'b1),
		.out_valid (in_vld),
		.out_ready (in_pop),
		.out_data  (in_dout),
		.count     (in_cnt)
	);

	// Outbound message queue
	msg_fifo #(.WIDTH(W), .DEPTH(OUT_DEPTH)) u_out_q (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.in_valid  (out_push),
		.in_ready  (out_rdy),
		.in_data   (ch_wdata),
		.overwrite (1'b0),
		.out_valid (out_vld),
		.out_ready (out_pop),
		.out_data  (out_dout),
		.count     (out_cnt)
	);

	// Outbound queue that interrupts the control processor
	msg_fifo #(.WIDTH(W), .DEPTH(OUTI_DEPTH)) u_outi_q (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.in_valid  (outi_push),
		.in_ready  (outi_rdy),
		.in_data   (ch_wdata),
		.overwrite (1'b0),
		.out_valid (outi_vld),
		.out_ready (outi_pop),
		.out_data  (outi_dout),
		.count     (outi_cnt)
	);

	// Channel answers; a slow core fills it and then stalls the channel's answering requests, but not its writes
	msg_fifo #(.WIDTH(W), .DEPTH(RSP_DEPTH)) u_rsp_q (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.in_valid  (rsp_push),
		.in_ready  (rsp_rdy),
		.in_data   (rsp_word),
		.overwrite (1'b0),
		.out_valid (ch_rsp_valid),
		.out_ready (ch_rsp_ready),
		.out_data  (ch_rsp_data),
		.count     ()
	);

	////////////////////////////////////////////////////////////////
	// Local core channel decode; ready low is the blocking stall

	always_comb begin
		ch_ready  = 1'b0;
		rsp_push  = 1'b0;
		rsp_word  = '0;
		in_pop    = 1'b0;
		out_push  = 1'b0;
		outi_push = 1'b0;
		case (ch_sel)
			mbox_pkg::CH_RD_IN: begin
				ch_ready = in_vld && rsp_rdy;
				in_pop   = ch_valid && ch_ready;
				rsp_push = in_pop;
				rsp_word = in_dout;
			end
			mbox_pkg::CH_WR_OUT: begin
				ch_ready = out_rdy;
				out_push = ch_valid && out_rdy;
			end
			mbox_pkg::CH_WR_OUTI: begin
				ch_ready  = outi_rdy;
				outi_push = ch_valid && outi_rdy;
			end
			mbox_pkg::CH_STAT_IN: begin
				ch_ready = rsp_rdy;
				rsp_push = ch_valid;
				rsp_word = as_word(8'(in_cnt));
			end
			mbox_pkg::CH_STAT_OUT: begin
				ch_ready = rsp_rdy;
				rsp_push = ch_valid;
				rsp_word = free_word(OUT_DEPTH, 8'(out_cnt));
			end
			mbox_pkg::CH_STAT_OUTI: begin
				ch_ready = rsp_rdy;
				rsp_push = ch_valid;
				rsp_word = free_word(OUTI_DEPTH, 8'(outi_cnt));
			end
			default: begin
				// Unused channel answers zero rather than hang the core
				ch_ready = rsp_rdy;
				rsp_push = ch_valid;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// External register side; DMA from other engines arrives here too

	assign ext_rd    = ext_valid && !ext_write;
	assign ext_in_wr = ext_valid && ext_write &&
		(ext_addr == mbox_pkg::EXT_IN_DATA);
	// Empty queue is left untouched on a read
	assign out_pop   = ext_rd && out_vld &&
		(ext_addr == mbox_pkg::EXT_OUT_DATA);
	assign outi_pop  = ext_rd && outi_vld &&
		(ext_addr == mbox_pkg::EXT_OUTI_DATA);

	// Answers and events one cycle after the access
	always_comb begin
		nxt         = r;
		nxt.rvalid  = ext_rd;
		nxt.rok     = 1'b1;
		nxt.rdata   = '0;
		nxt.ev_in   = ext_in_wr;
		nxt.ev_out  = out_pop;
		nxt.ev_outi = outi_pop;
		if (ext_rd) begin
			case (ext_addr)
				mbox_pkg::EXT_IN_STAT: begin
					nxt.rdata = as_word(8'(in_cnt));
				end
				mbox_pkg::EXT_OUT_DATA: begin
					nxt.rdata = out_dout;
					nxt.rok   = out_vld;
				end
				mbox_pkg::EXT_OUT_STAT: begin
					nxt.rdata = free_word(OUT_DEPTH, 8'(out_cnt));
				end
				mbox_pkg::EXT_OUTI_DATA: begin
					nxt.rdata = outi_dout;
					nxt.rok   = outi_vld;
				end
				mbox_pkg::EXT_OUTI_STAT: begin
					nxt.rdata = free_word(OUTI_DEPTH, 8'(outi_cnt));
				end
				default: begin
					nxt.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end

	assign ext_rsp_valid     = r.rvalid;
	assign ext_rsp_data      = r.rdata;
	assign ext_rsp_ok        = r.rok;
	assign evt_in_written    = r.ev_in;
	assign evt_out_read      = r.ev_out;
	assign evt_out_intr_read = r.ev_outi;
	// Held while an unread message waits
	assign ctrl_irq          = outi_vld;

	////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	chk_in_overwrite: assert property (
		ext_in_wr && !in_pop && in_cnt == ICW'(IN_DEPTH)
		|=> in_cnt == ICW'(IN_DEPTH) && evt_in_written)
		else $error("inbound overwrite changed the count");

	chk_in_count_up: assert property (
		ext_in_wr && !in_pop && in_cnt < ICW'(IN_DEPTH)
		|=> in_cnt == $past(in_cnt) + 1'b1)
		else $error("inbound count did not rise");

	chk_empty_rd_stall: assert property (
		ch_valid && ch_sel == mbox_pkg::CH_RD_IN && in_cnt == '0
		|-> !ch_ready)
		else $error("core read of empty inbound not stalled");

	chk_full_wr_stall: assert property (
		ch_valid && ch_sel == mbox_pkg::CH_WR_OUT &&
		out_cnt == OCW'(OUT_DEPTH) |-> !ch_ready)
		else $error("core write to full outbound not stalled");

	chk_empty_ext_read: assert property (
		ext_rd && ext_addr == mbox_pkg::EXT_OUT_DATA && out_cnt == '0
		&& !out_push |=> ext_rsp_valid && !ext_rsp_ok &&
		out_cnt == '0 && !evt_out_read)
		else $error("empty outbound read misbehaved");

	chk_read_consumes: assert property (
		out_pop && !out_push |=> out_cnt == $past(out_cnt) - 1'b1
		##0 evt_out_read)
		else $error("outbound read did not consume entry");

	chk_irq_raise: assert property (
		outi_push |=> ctrl_irq && outi_cnt == $past(outi_cnt) + 1'b1)
		else $error("interrupt not raised by core write");

	chk_irq_clear: assert property (
		outi_pop && !outi_push |=> !ctrl_irq && evt_out_intr_read)
		else $error("interrupt not cleared by read");

	chk_nb_latency: assert property (
		ch_valid && ch_ready && rsp_push && !ch_rsp_valid
		|-> ##[1:LAT] ch_rsp_valid)
		else $error("channel answer later than allowed");

	chk_reset_counts: assert property (
		$past(srst) |-> in_cnt == ICW'(mbox_pkg::RST_IN_VALID) &&
		free_word(OUT_DEPTH, 8'(out_cnt)) ==
		W'(mbox_pkg::RST_OUT_EMPTY) &&
		free_word(OUTI_DEPTH, 8'(outi_cnt)) ==
		W'(mbox_pkg::RST_OUT_EMPTY))
		else $error("counters wrong after reset");

	cov_in_full: cover property (ext_in_wr && in_cnt == ICW'(IN_DEPTH));
	cov_out_stall: cover property (ch_valid && ch_sel ==
		mbox_pkg::CH_WR_OUT && !ch_ready ##[1:20] ch_ready);
	cov_irq_cycle: cover property (outi_push ##[1:20] outi_pop);
	cov_rsp_full: cover property (ch_valid && !rsp_rdy);

endmodule

`default_nettype wire

// file: common/mbox_pkg.sv
// Constants and types shared by the mailbox unit
`default_nettype none

package mbox_pkg;

	// Message word and queue shapes
	localparam int MSG_W      = 32;
	localparam int IN_DEPTH   = 4;
	localparam int OUT_DEPTH  = 1;
	localparam int OUTI_DEPTH = 1;
	localparam int RSP_DEPTH  = 8;

	// Longest channel answer for a non-blocking access, in cycles
	localparam int NB_LAT_MAX = 6;

	// Counter values after reset
	localparam int RST_IN_VALID  = 0;
	localparam int RST_OUT_EMPTY = 1;

	// External register indices (one word each)
	localparam int EXT_AW = 3;
	localparam logic [EXT_AW-1:0] EXT_IN_DATA   = 3'h0;
	localparam logic [EXT_AW-1:0] EXT_IN_STAT   = 3'h1;
	localparam logic [EXT_AW-1:0] EXT_OUT_DATA  = 3'h2;
	localparam logic [EXT_AW-1:0] EXT_OUT_STAT  = 3'h3;
	localparam logic [EXT_AW-1:0] EXT_OUTI_DATA = 3'h4;
	localparam logic [EXT_AW-1:0] EXT_OUTI_STAT = 3'h5;

	// Local core channel selections
	typedef enum logic [2:0] {
		CH_RD_IN,
		CH_WR_OUT,
		CH_WR_OUTI,
		CH_STAT_IN,
		CH_STAT_OUT,
		CH_STAT_OUTI
	} ch_sel_t;

endpackage

`default_nettype wire

// file: testbench/ext_requester.sv
// Behavioural processor or remote engine on the register side
`timescale 1ns/1ns
`default_nettype none

module ext_requester (
	input  wire logic                       clk_sys,
	output logic                            ext_valid,
	output logic                            ext_write,
	output logic [mbox_pkg::EXT_AW-1:0]     ext_addr,
	output logic [mbox_pkg::MSG_W-1:0]      ext_wdata,
	input  wire logic                       ext_rsp_valid,
	input  wire logic [mbox_pkg::MSG_W-1:0] ext_rsp_data,
	input  wire logic                       ext_rsp_ok
);
	initial begin
		ext_valid = 1'b0;
		ext_write = 1'b0;
		ext_addr = '0;
		ext_wdata = '0;
	end

	////////////////////////////////////////////////////////////////
	// One access per call; DMA from a remote engine looks the same
	task automatic acc(input logic w, input logic [2:0] a,
		input logic [31:0] d, output logic [31:0] r,
		output logic ok, output logic rv);
		@(negedge clk_sys);
		ext_valid = 1'b1;
		ext_write = w;
		ext_addr = a;
		ext_wdata = d;
		@(negedge clk_sys);
		ext_valid = 1'b0;
		ext_wdata = ~d; // Released bus must not show a stale word
		r = ext_rsp_data;
		ok = ext_rsp_ok;
		rv = ext_rsp_valid;
	endtask

	// Counter poll before touching a data register
	task automatic poll(input logic [2:0] a, output logic [31:0] c);
		logic ok;
		logic rv;
		acc(1'b0, a, 32'h0, c, ok, rv);
	endtask
endmodule

`default_nettype wire

// file: testbench/core_message_mailboxes_tb.sv
// Self-checking bench for the mailbox unit
`timescale 1ns/1ns
`default_nettype none

module core_message_mailboxes_tb;
	logic                clk_sys;
	logic                srst;
	logic                ch_valid;
	logic                ch_ready;
	mbox_pkg::ch_sel_t   ch_sel;
	logic [31:0]         ch_wdata;
	logic                ch_rsp_valid;
	logic                ch_rsp_ready;
	logic [31:0]         ch_rsp_data;
	logic                ext_valid;
	logic                ext_write;
	logic [2:0]          ext_addr;
	logic [31:0]         ext_wdata;
	logic                ext_rsp_valid;
	logic [31:0]         ext_rsp_data;
	logic                ext_rsp_ok;
	logic                evt_in_written;
	logic                evt_out_read;
	logic                evt_out_intr_read;
	logic                ctrl_irq;
	logic [31:0]         in_q[$];
	logic [31:0]         out_q[$];
	logic [31:0]         outi_q[$];
	int                  n_fail = 0;
	int                  comparisons = 0;
	int                  cyc = 0;

	core_message_mailboxes uut (.clk_sys(clk_sys), .srst(srst),
		.ch_valid(ch_valid), .ch_ready(ch_ready), .ch_sel(ch_sel),
		.ch_wdata(ch_wdata), .ch_rsp_valid(ch_rsp_valid),
		.ch_rsp_ready(ch_rsp_ready), .ch_rsp_data(ch_rsp_data),
		.ext_valid(ext_valid), .ext_write(ext_write),
		.ext_addr(ext_addr), .ext_wdata(ext_wdata),
		.ext_rsp_valid(ext_rsp_valid), .ext_rsp_data(ext_rsp_data),
		.ext_rsp_ok(ext_rsp_ok), .evt_in_written(evt_in_written),
		.evt_out_read(evt_out_read),
		.evt_out_intr_read(evt_out_intr_read), .ctrl_irq(ctrl_irq));

	ext_requester req (.clk_sys(clk_sys), .ext_valid(ext_valid),
		.ext_write(ext_write), .ext_addr(ext_addr),
		.ext_wdata(ext_wdata), .ext_rsp_valid(ext_rsp_valid),
		.ext_rsp_data(ext_rsp_data), .ext_rsp_ok(ext_rsp_ok));

	////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			final_report;
		end
	end

	task automatic final_report;
		$display("Counts: %0d compares, %0d mismatches", comparisons,
			n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////
	// Expected free entries, from the outbound queue models
	function automatic logic [31:0] out_free();
		return 32'(mbox_pkg::OUT_DEPTH - out_q.size());
	endfunction

	function automatic logic [31:0] outi_free();
		return 32'(mbox_pkg::OUTI_DEPTH - outi_q.size());
	endfunction

	// Channel side: request held until the edge that sees ready high;
	// ready is read a step after the falling edge, once settled, since
	// right after the drive it still shows the previous selection
	task automatic ch_req(input mbox_pkg::ch_sel_t s, input logic [31:0] d);
		int k;
		@(negedge clk_sys);
		ch_valid = 1'b1;
		ch_sel = s;
		ch_wdata = d;
		k = 0;
		#1;
		while (ch_ready !== 1'b1 && k < 400) begin
			@(negedge clk_sys);
			#1;
			k++;
		end
		@(negedge clk_sys);
		ch_valid = 1'b0;
		ch_wdata = ~d;
	endtask

	task automatic ch_read(input mbox_pkg::ch_sel_t s, output logic [31:0] r);
		int k;
		ch_req(s, $urandom);
		k = 1;
		while (ch_rsp_valid !== 1'b1 && k < 20) begin
			@(negedge clk_sys);
			k++;
		end
		check(k <= mbox_pkg::NB_LAT_MAX, 1);
		r = ch_rsp_data;
		ch_rsp_ready = 1'b1;
		@(negedge clk_sys);
		ch_rsp_ready = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	// Register side helpers
	task automatic ext(input logic w, input logic [2:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic ok);
		logic rv;
		req.acc(w, a, d, r, ok, rv);
		check(rv, !w);
	endtask

	// Removing read of an outbound queue; empty gives ok low
	task automatic out_pop(input logic [2:0] a, ref logic [31:0] q[$],
		output logic e);
		logic [31:0] r;
		logic ok;
		e = q.size() != 0;
		ext(1'b0, a, $urandom, r, ok);
		check(ok, e);
		if (e) check(r, q.pop_front());
	endtask

	task automatic check_counts;
		logic [31:0] c;
		req.poll(mbox_pkg::EXT_IN_STAT, c);
		check(c, in_q.size());
		req.poll(mbox_pkg::EXT_OUT_STAT, c);
		check(c, out_free());
		req.poll(mbox_pkg::EXT_OUTI_STAT, c);
		check(c, outi_free());
		ch_read(mbox_pkg::CH_STAT_OUTI, c);
		check(c, outi_free());
		ch_read(mbox_pkg::CH_STAT_OUT, c);
		check(c, out_free());
		ch_read(mbox_pkg::CH_STAT_IN, c);
		check(c, in_q.size());
		check(ctrl_irq, outi_q.size() != 0);
	endtask

	// One operation; blocking core accesses only where they cannot stall
	task automatic op(input int k);
		logic [31:0] d;
		logic [31:0] r;
		logic ok;
		logic e;
		d = $urandom;
		case (k)
			0: begin
				ext(1'b1, mbox_pkg::EXT_IN_DATA, d, r, ok);
				if (in_q.size() == mbox_pkg::IN_DEPTH)
					in_q[mbox_pkg::IN_DEPTH-1] = d;
				else
					in_q.push_back(d);
				check(evt_in_written, 1);
			end
			1: if (in_q.size() != 0) begin
				ch_read(mbox_pkg::CH_RD_IN, r);
				check(r, in_q.pop_front());
			end
			2: if (out_q.size() == 0) begin
				ch_req(mbox_pkg::CH_WR_OUT, d);
				out_q.push_back(d);
			end
			3: if (outi_q.size() == 0) begin
				ch_req(mbox_pkg::CH_WR_OUTI, d);
				outi_q.push_back(d);
			end
			4: begin
				out_pop(mbox_pkg::EXT_OUT_DATA, out_q, e);
				check(evt_out_read, e);
			end
			default: begin
				out_pop(mbox_pkg::EXT_OUTI_DATA, outi_q, e);
				check(evt_out_intr_read, e);
			end
		endcase
		check_counts;
	endtask

	task automatic do_reset;
		srst = 1'b1;
		repeat (8) @(negedge clk_sys);
		srst = 1'b0;
		in_q.delete();
		out_q.delete();
		outi_q.delete();
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] r;
		logic [31:0] x;
		logic ok;
		logic e;
		srst = 1'b1;
		ch_valid = 1'b0;
		ch_sel = mbox_pkg::CH_STAT_IN;
		ch_wdata = '0;
		ch_rsp_ready = 1'b0;
		void'($urandom(32'h7a9b5db8));
		do_reset;
		check_counts;
		$display("Test done: reset state");
		repeat (mbox_pkg::IN_DEPTH + 2) op(0);
		repeat (mbox_pkg::IN_DEPTH + 1) op(1);
		$display("Test done: inbound overrun");
		fork
			ch_read(mbox_pkg::CH_RD_IN, r);
			begin
				repeat (4) @(negedge clk_sys);
				check(ch_ready, 0);
				ext(1'b1, mbox_pkg::EXT_IN_DATA, 32'h5a5a0001, x, ok);
			end
		join
		check(r, 32'h5a5a0001);
		$display("Test done: empty inbound stall");
		op(2);
		fork
			ch_req(mbox_pkg::CH_WR_OUT, 32'h0f0f1234);
			begin
				repeat (4) @(negedge clk_sys);
				check(ch_ready, 0);
				out_pop(mbox_pkg::EXT_OUT_DATA, out_q, e);
			end
		join
		out_q.push_back(32'h0f0f1234);
		check_counts;
		$display("Test done: full outbound stall");
		repeat (300) op($urandom_range(5));
		$display("Test done: random traffic");
		op(3);
		op(0);
		do_reset;
		check_counts;
		$display("Test done: reset in mid-run");
		final_report;
	end
endmodule

`default_nettype wire
